// >>> src/qdr_cmd_fsm.sv
// Command-layer state machine for queued DMA read commands.
`timescale 1ns/10ps
`default_nettype none
module qdr_cmd_fsm
    import qdr_pkg::*;
#(
    parameter int MAX_DW = QDR_MAX_DW,
    parameter int DEPTH = QDR_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic cmd_start,
    input wire logic [QDR_LEN_W-1:0] cmd_dwords,
    input wire logic release_irq_en,
    input wire logic data_ready,
    input wire logic abort_err,
    input wire logic src_valid,
    input wire logic [QDR_DATA_W-1:0] src_data,
    output logic src_ready,
    output logic data_fis_req,
    output logic [QDR_LEN_W-1:0] data_fis_dwords,
    input wire logic data_fis_done,
    output logic tx_valid,
    output logic [QDR_DATA_W-1:0] tx_data,
    output logic tx_last,
    input wire logic tx_ready,
    output logic reg_fis_req,
    output logic [1:0] reg_fis_kind,
    output logic reg_fis_irq,
    output logic reg_fis_rel,
    input wire logic reg_fis_done,
    output logic busy,
    output logic cmd_queued
);
    qdr_state_e state_q;
    qdr_state_e state_d;
    logic [QDR_LEN_W-1:0] left_q;
    logic [QDR_LEN_W-1:0] chunk_q;
    logic data_started_q;
    logic src_ready_q;

    qdr_fifo_if #(.WIDTH(QDR_DATA_W)) fin ();
    qdr_fifo_if #(.WIDTH(QDR_DATA_W)) fout ();

    ////////////////////////////////////////////////////////////////////////
    // Payload path through the FIFO.

    // Source back-pressure is registered so the output is a flop; the FIFO
    // is written only while last cycle's ready was given.
    assign fin.valid = src_valid && src_ready_q;
    assign fin.data = src_data;
    assign fout.ready = tx_ready && (state_q == QDR_SEND) && (chunk_q != '0);

    qdr_fifo #(.WIDTH(QDR_DATA_W), .DEPTH(DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .wr(fin),
        .rd(fout)
    );

    // Words leave in the send state only; chunk_q counts the frame down.
    wire logic word_go = fout.valid && fout.ready;

    // Registered ready may only promise room that is sure to remain, so a
    // push without a pop drops it for a cycle; this halves the fill rate.
    wire logic src_room = fin.ready && (!(fin.valid && fin.ready) || word_go);

    // Clamp a length to the frame maximum.
    function automatic logic [QDR_LEN_W-1:0] clamp_len(
        input logic [QDR_LEN_W-1:0] n
    );
        clamp_len = (n > QDR_LEN_W'(MAX_DW)) ? QDR_LEN_W'(MAX_DW) : n;
    endfunction : clamp_len

    ////////////////////////////////////////////////////////////////////////
    // Next-state decode.

    wire logic all_sent = (left_q == '0);
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            QDR_IDLE: begin
                if (cmd_start) begin
                    state_d = QDR_DECIDE;
                end
            end
            QDR_DECIDE: begin
                if (abort_err) begin
                    state_d = QDR_STATUS;
                end else if (data_ready) begin
                    state_d = QDR_SEND;
                end else begin
                    state_d = QDR_RELEASE;
                end
            end
            QDR_SEND: begin
                if (data_fis_done) begin
                    state_d = QDR_PREPARE;
                end
            end
            QDR_PREPARE: begin
                if (all_sent || abort_err) begin
                    state_d = QDR_STATUS;
                end else if (data_ready) begin
                    state_d = QDR_SEND;
                end
            end
            QDR_STATUS: begin
                if (reg_fis_done) begin
                    state_d = QDR_IDLE;
                end
            end
            QDR_RELEASE: begin
                if (reg_fis_done) begin
                    state_d = QDR_IDLE;
                end
            end
            default: begin
                state_d = QDR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State and counters.

    // Remaining length is loaded at command receipt and reduced per word.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= QDR_IDLE;
            left_q <= '0;
            chunk_q <= '0;
            data_started_q <= 1'b0;
            src_ready_q <= 1'b0;
        end else begin
            state_q <= state_d;
            src_ready_q <= src_room;
            if (state_q == QDR_IDLE && cmd_start) begin
                left_q <= cmd_dwords;
                data_started_q <= 1'b0;
            end else if (word_go) begin
                left_q <= left_q - 1'b1;
            end
            if (state_d == QDR_SEND && state_q != QDR_SEND) begin
                chunk_q <= clamp_len(left_q);
                data_started_q <= 1'b1;
            end else if (word_go) begin
                chunk_q <= chunk_q - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs toward the transport layer.

    // Every output is a flop; frame requests hold while the state does.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            data_fis_req <= 1'b0;
            data_fis_dwords <= '0;
            reg_fis_req <= 1'b0;
            reg_fis_kind <= 2'h0;
            reg_fis_irq <= 1'b0;
            reg_fis_rel <= 1'b0;
            busy <= 1'b0;
            cmd_queued <= 1'b0;
            src_ready <= 1'b0;
        end else begin
            src_ready <= src_room;
            data_fis_req <= (state_d == QDR_SEND);
            if (state_d == QDR_SEND && state_q != QDR_SEND) begin
                data_fis_dwords <= clamp_len(left_q);
            end
            reg_fis_req <= (state_d == QDR_STATUS) ||
                (state_d == QDR_RELEASE);
            if (state_d == QDR_STATUS) begin
                reg_fis_kind <= QDR_REG_STATUS;
                reg_fis_irq <= 1'b1;
                reg_fis_rel <= 1'b0;
            end else if (state_d == QDR_RELEASE) begin
                reg_fis_kind <= QDR_REG_RELEASE;
                reg_fis_irq <= release_irq_en;
                reg_fis_rel <= 1'b1;
            end else begin
                reg_fis_kind <= 2'h0;
                reg_fis_irq <= 1'b0;
                reg_fis_rel <= 1'b0;
            end
            busy <= (state_d != QDR_IDLE);
            if (state_q == QDR_RELEASE && reg_fis_done) begin
                cmd_queued <= 1'b1;
            end else if (state_q == QDR_IDLE && cmd_start) begin
                cmd_queued <= 1'b0;
            end
        end
    end

    // Stream toward transport, registered with a skid-free handshake.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_valid <= 1'b0;
            tx_data <= '0;
            tx_last <= 1'b0;
        end else begin
            tx_valid <= word_go;
            tx_data <= fout.data;
            tx_last <= word_go && (chunk_q == QDR_LEN_W'(1));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    property p_decide_send;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q == QDR_DECIDE && !abort_err && data_ready)
            |=> state_q == QDR_SEND ##0 data_fis_req;
    endproperty
    a_decide_send: assert property (p_decide_send)
        else $error("decide with data ready did not send");

    property p_err_first;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q == QDR_DECIDE && abort_err) |=> state_q == QDR_STATUS;
    endproperty
    a_err_first: assert property (p_err_first)
        else $error("error in decide did not go to status");

    property p_decide_rel;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q == QDR_DECIDE && !abort_err && !data_ready)
            |=> reg_fis_rel && reg_fis_req;
    endproperty
    a_decide_rel: assert property (p_decide_rel)
        else $error("decide without data did not release");

    property p_frame_cap;
        @(posedge clk_sys) disable iff (!reset_n)
        data_fis_req |-> data_fis_dwords <= QDR_LEN_W'(MAX_DW);
    endproperty
    a_frame_cap: assert property (p_frame_cap)
        else $error("data frame longer than allowed");

    property p_no_rel_after;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q != QDR_IDLE && data_started_q) |-> !reg_fis_rel;
    endproperty
    a_no_rel_after: assert property (p_no_rel_after)
        else $error("bus release after data started");

    property p_status_irq;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q == QDR_STATUS) |-> reg_fis_irq && !reg_fis_rel;
    endproperty
    a_status_irq: assert property (p_status_irq)
        else $error("status frame without interrupt bit");

    property p_rel_irq;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q != QDR_RELEASE ##1 state_q == QDR_RELEASE)
            |-> reg_fis_irq == $past(release_irq_en);
    endproperty
    a_rel_irq: assert property (p_rel_irq)
        else $error("release interrupt bit not per enable");

    property p_done_idle;
        @(posedge clk_sys) disable iff (!reset_n)
        ((state_q == QDR_STATUS || state_q == QDR_RELEASE) && reg_fis_done)
            |=> state_q == QDR_IDLE && !busy;
    endproperty
    a_done_idle: assert property (p_done_idle)
        else $error("register frame done but not idle");

    property p_prep_status;
        @(posedge clk_sys) disable iff (!reset_n)
        (state_q == QDR_PREPARE && all_sent) |=> state_q == QDR_STATUS;
    endproperty
    a_prep_status: assert property (p_prep_status)
        else $error("prepare with all sent did not go to status");
endmodule : qdr_cmd_fsm
`default_nettype wire

// >>> src/qdr_pkg.sv
// Package for the queued DMA read command state machine.
// How it works
// - A queued read command enters the decide state to check data readiness.
// - Decide with data ready and no error moves to the send state.
// - Decide with an aborting error moves to the status state.
// - Decide with neither ready data nor an error moves to the release state.
// - Send state asks transport to transmit one data frame.
// - Each data frame carries at most 2048 doublewords; longer transfers split.
// - Transport done with the data frame moves to the prepare state.
// - Prepare with next data ready, data left to send and no error returns to the send state.
// - Prepare with all data sent or an error moves to status.
// - Status state sends a register frame with the interrupt bit set.
// - After the status frame is sent the device goes idle.
// - Release state sends a register frame with the release bit set.
// - Release frame interrupt bit follows the release interrupt enable.
// - After the release frame the device goes idle, command stays queued.
// - Once data starts, all of it goes without a bus release.
// - Release happens only before data, or never for the command.
package qdr_pkg;
    localparam int QDR_MAX_DW = 2048;
    localparam int QDR_LEN_W = 16;
    localparam int QDR_DATA_W = 32;
    localparam int QDR_FIFO_DEPTH = 4;
    localparam logic [1:0] QDR_REG_STATUS = 2'h1;
    localparam logic [1:0] QDR_REG_RELEASE = 2'h2;

    typedef enum logic [5:0] {
        QDR_IDLE = 6'h01,
        QDR_DECIDE = 6'h02,
        QDR_SEND = 6'h04,
        QDR_PREPARE = 6'h08,
        QDR_STATUS = 6'h10,
        QDR_RELEASE = 6'h20
    } qdr_state_e;
endpackage : qdr_pkg

// >>> src/qdr_fifo_if.sv
// Interface carrying one valid/ready stream between the block's modules.
`timescale 1ns/10ps
`default_nettype none
interface qdr_fifo_if #(parameter int WIDTH = 32);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : qdr_fifo_if
`default_nettype wire

// >>> src/qdr_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module qdr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    qdr_fifo_if.snk wr,
    qdr_fifo_if.src rd
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] cnt_q;
    wire logic push;
    wire logic pop;

    // Full and empty come from the occupancy count so they never lie.
    assign wr.ready = (cnt_q < (AW+1)'(DEPTH));
    assign rd.valid = (cnt_q != '0);
    assign rd.data = mem_q[rptr_q];
    assign push = wr.valid && wr.ready;
    assign pop = rd.valid && rd.ready;

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH-1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH-1)) ? '0 : rptr_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

    // Storage has no reset; only written slots are ever read.
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wptr_q] <= wr.data;
        end
    end

    // Count never exceeds the depth.
    property p_fifo_bound;
        @(posedge clk_sys) disable iff (!reset_n)
        cnt_q <= (AW+1)'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound)
        else $error("fifo occupancy above depth");
endmodule : qdr_fifo
`default_nettype wire

// >>> verif/qdr_xport_model.sv
// Transport model that drains data frames and sends register frames.
`timescale 1ns/10ps
`default_nettype none
module qdr_xport_model (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic slow,
    input wire logic data_fis_req,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic data_fis_done,
    input wire logic reg_fis_req,
    output logic reg_fis_done
);
    logic got_last;
    logic phase;
    logic hold;
    int wait_cnt;
    // Note the edge that moved the last word of a frame.
    always @(posedge clk_sys) got_last <= tx_valid && tx_last;
    // Outputs move on the falling edge; hold blocks a second done pulse.
    always @(negedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            tx_ready = 1'b0;
            data_fis_done = 1'b0;
            reg_fis_done = 1'b0;
            phase = 1'b0;
            hold = 1'b0;
            wait_cnt = 0;
        end else begin
            phase = ~phase;
            tx_ready = data_fis_req && (phase || !slow);
            data_fis_done = got_last;
            reg_fis_done = 1'b0;
            if (!reg_fis_req) hold = 1'b0;
            if (reg_fis_req && !hold) wait_cnt = wait_cnt + 1;
            if (wait_cnt > (slow ? 4 : 0)) begin
                reg_fis_done = 1'b1;
                hold = 1'b1;
                wait_cnt = 0;
            end
        end
    end
endmodule : qdr_xport_model
`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the queued read command state machine.
`timescale 1ns/10ps
`default_nettype none
module testbench
    import qdr_pkg::*;
;
    localparam int MAX_T = 8;
    logic clk_sys, reset_n, cmd_start, release_irq_en, data_ready, slow;
    logic abort_err, src_valid, src_ready, data_fis_req, data_fis_done;
    logic tx_valid, tx_last, tx_ready, reg_fis_req, reg_fis_irq, fed;
    logic reg_fis_rel, reg_fis_done, busy, cmd_queued, req_q, data_seen;
    logic [1:0] reg_fis_kind;
    logic [QDR_LEN_W-1:0] cmd_dwords, data_fis_dwords;
    logic [QDR_DATA_W-1:0] src_data, tx_data, feed_word, exp_word;
    logic [QDR_LEN_W-1:0] lens[$];
    int n_mismatch, checks_done, feed_left, frame_cnt, tot_words, cycles;

    qdr_cmd_fsm #(.MAX_DW(MAX_T), .DEPTH(QDR_FIFO_DEPTH)) u_dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .cmd_start(cmd_start),
        .cmd_dwords(cmd_dwords), .release_irq_en(release_irq_en),
        .data_ready(data_ready), .abort_err(abort_err),
        .src_valid(src_valid), .src_data(src_data), .src_ready(src_ready),
        .data_fis_req(data_fis_req), .data_fis_dwords(data_fis_dwords),
        .data_fis_done(data_fis_done), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
        .reg_fis_req(reg_fis_req), .reg_fis_kind(reg_fis_kind),
        .reg_fis_irq(reg_fis_irq), .reg_fis_rel(reg_fis_rel),
        .reg_fis_done(reg_fis_done), .busy(busy), .cmd_queued(cmd_queued)
    );
    qdr_xport_model u_xport (
        .clk_sys(clk_sys), .reset_n(reset_n), .slow(slow),
        .data_fis_req(data_fis_req), .tx_valid(tx_valid),
        .tx_last(tx_last), .tx_ready(tx_ready),
        .data_fis_done(data_fis_done), .reg_fis_req(reg_fis_req),
        .reg_fis_done(reg_fis_done)
    );

    ////////////////////////////////////////////////////////////////////
    // Clock at 40 MHz.
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Source feeder; an idle data line shows the inverse, not stale data.
    always @(negedge clk_sys) begin
        if (fed) begin
            feed_left = feed_left - 1;
            feed_word = feed_word + 1;
        end
        src_valid = feed_left > 0;
        src_data = src_valid ? feed_word : ~feed_word;
    end
    // Stream monitor: word order, frame lengths, no release after data.
    always @(posedge clk_sys) begin
        fed <= src_valid && src_ready;
        req_q <= data_fis_req;
        cycles = cycles + 1;
        if (data_fis_req && !req_q) lens.push_back(data_fis_dwords);
        if (tx_valid) begin
            check(tx_data, exp_word);
            exp_word = exp_word + 1;
            frame_cnt = frame_cnt + 1;
            tot_words = tot_words + 1;
            data_seen = 1'b1;
            if (tx_last) begin
                check(frame_cnt, data_fis_dwords);
                frame_cnt = 0;
            end
        end
        if (reg_fis_req && data_seen) check(reg_fis_rel, 1'b0);
        if (cycles == 20000) begin
            n_mismatch = n_mismatch + 1;
            finish_test();
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Shared helpers.
    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    // Leaves the caller at the falling edge half a cycle after the take.
    task start_cmd(input int len);
        @(negedge clk_sys);
        cmd_dwords = len[15:0];
        cmd_start = 1'b1;
        data_seen = 1'b0;
        tot_words = 0;
        frame_cnt = 0;
        lens.delete();
        @(negedge clk_sys);
        cmd_start = 1'b0;
    endtask : start_cmd
    task wait_for(input logic want, input bit on_reg);
        int i;
        for (i = 0; i < 3000; i++) begin
            if ((on_reg ? reg_fis_req : busy) === want) break;
            @(negedge clk_sys);
        end
    endtask : wait_for

    ////////////////////////////////////////////////////////////////////
    // Full FIFO refuses, then a long read splits into short frames.
    task sc_split;
        slow = 1'b1;
        data_ready = 1'b1;
        feed_word = 32'h0000_1000;
        exp_word = feed_word;
        feed_left = 20;
        repeat (12) @(negedge clk_sys);
        check(src_ready, 1'b0); // buffer full
        start_cmd(20);
        check(busy, 1'b1);
        @(negedge clk_sys);
        check(data_fis_req, 1'b1);
        wait_for(1'b1, 1'b1);
        check(reg_fis_kind, QDR_REG_STATUS);
        check(reg_fis_irq, 1'b1);
        check(tot_words, 20);
        check(lens.size(), 3);
        check(lens[0], MAX_T);
        check(lens[2], 4);
        wait_for(1'b0, 1'b0);
        check(busy, 1'b0);
        check(cmd_queued, 1'b0);
        check(feed_left, 0); // source drained
    endtask : sc_split
    // Error and ready together at decide go to status.
    task sc_abort_first;
        abort_err = 1'b1;
        start_cmd(4);
        @(negedge clk_sys);
        check(data_fis_req, 1'b0);
        check(reg_fis_req, 1'b1);
        check(reg_fis_kind, QDR_REG_STATUS);
        abort_err = 1'b0;
        wait_for(1'b0, 1'b0);
        check(tot_words, 0);
    endtask : sc_abort_first
    // Release frame with the interrupt bit off and on.
    task sc_release;
        int en;
        data_ready = 1'b0;
        for (en = 0; en < 2; en++) begin
            release_irq_en = en[0];
            slow = en[0];
            start_cmd(4);
            @(negedge clk_sys);
            check(reg_fis_req, 1'b1);
            check(reg_fis_kind, QDR_REG_RELEASE);
            check(reg_fis_rel, 1'b1);
            check(reg_fis_irq, en[0]);
            wait_for(1'b0, 1'b0);
            check(cmd_queued, 1'b1);
        end
    endtask : sc_release
    // Prepare waits without releasing, then an error ends the read.
    task sc_abort_mid;
        slow = 1'b0;
        data_ready = 1'b1;
        feed_left = 12;
        start_cmd(12);
        @(negedge clk_sys);
        data_ready = 1'b0;
        while (data_fis_req === 1'b1 && cycles < 19000) @(negedge clk_sys);
        repeat (4) @(negedge clk_sys);
        check(reg_fis_req, 1'b0);
        check(data_fis_req, 1'b0);
        abort_err = 1'b1;
        wait_for(1'b1, 1'b1);
        check(reg_fis_kind, QDR_REG_STATUS);
        check(tot_words, MAX_T);
        abort_err = 1'b0;
        feed_left = 0;
        wait_for(1'b0, 1'b0);
    endtask : sc_abort_mid

    ////////////////////////////////////////////////////////////////////
    // Verdict and end of run.
    task finish_test;
        $display("mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : finish_test
    // Main sequence; busy, tx_valid and both frame requests must read zero while reset is held.
    initial begin
        {reset_n, cmd_start, release_irq_en, data_ready, abort_err} = '0;
        {slow, src_valid, fed, req_q, data_seen} = '0;
        cmd_dwords = '0;
        src_data = '0;
        feed_word = '0;
        exp_word = '0;
        {n_mismatch, checks_done, feed_left, frame_cnt, tot_words} = '0;
        cycles = 0;
        repeat (3) @(negedge clk_sys);
        check({busy, data_fis_req, tx_valid, reg_fis_req}, 4'h0);
        reset_n = 1'b1;
        sc_split();
        sc_abort_first();
        sc_release();
        sc_abort_mid();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
